// [logic/als_pkg.sv]
`default_nettype none
package light_zone_pkg;
    // Clock and sampling
    localparam int CLK_MHZ = 50;
    localparam int SAMPLE_PERIOD_NS = 140000;
    localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_NS * CLK_MHZ / 1000;
    localparam int FAST_PERIOD_NS = 1100000;
    localparam int FAST_SAMPLES = (FAST_PERIOD_NS + SAMPLE_PERIOD_NS - 1) / SAMPLE_PERIOD_NS;
    localparam int FAST_SHIFT = $clog2(FAST_SAMPLES);
    localparam int FAST_PERIOD_COUNT = 3;
    localparam int NORMAL_SHIFT_BASE = 4;
    localparam int QUAL_PERIODS = 3;
    localparam int DOWN_EXTRA_BASE = 3;
    // Sizes
    localparam int NUM_ZONES = 5;
    localparam int NUM_BOUNDS = 4;
    localparam int NUM_MAPPERS = 3;
    localparam int NUM_BANKS = 6;
    // Register offsets
    localparam logic [7:0] OFF_CFG = 8'h31;
    localparam logic [7:0] OFF_RES_SEL = 8'h32;
    localparam logic [7:0] OFF_ALGO = 8'h33;
    localparam logic [7:0] OFF_BANK_ASG = 8'h34;
    localparam logic [7:0] OFF_PWM_ZONE = 8'h35;
    localparam logic [7:0] OFF_DOWN_DELAY = 8'h36;
    localparam logic [7:0] OFF_SAMPLE = 8'h37;
    localparam logic [7:0] OFF_AVERAGE = 8'h38;
    localparam logic [7:0] OFF_ZONE = 8'h39;
    localparam logic [7:0] OFF_BOUND_HI = 8'h50;
    localparam logic [7:0] OFF_BOUND_LO = 8'h54;
    localparam logic [7:0] OFF_TARGET = 8'h60;
    // Field positions
    localparam int CFG_EN_BIT = 0;
    localparam int CFG_PWM_BIT = 1;
    localparam int CFG_AVG_LSB = 3;
    // Reset values
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [6:0] RES_SEL_RST = 7'h00;
    localparam logic [5:0] ALGO_RST = 6'h00;
    localparam logic [5:0] BANK_ASG_RST = 6'h3f;
    localparam logic [4:0] PWM_ZONE_RST = 5'h00;
    localparam logic [4:0] DOWN_DELAY_RST = 5'h00;
    localparam logic [7:0] BOUND_RST = 8'hff;
    localparam logic [7:0] TARGET_RST = 8'h00;
    localparam logic [6:0] RES_HIGHZ = 7'h00;

    typedef logic [2:0] zone_t;
    typedef enum logic [1:0] {ALGO_DIRECT, ALGO_UP_ONLY, ALGO_DOWN_DELAY, ALGO_SPARE} algo_t;
    typedef enum logic [1:0] {SENSE_IDLE, SENSE_FAST, SENSE_NORMAL} sense_t;
endpackage: light_zone_pkg
`default_nettype wire

// [logic/mapper_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface mapper_if import light_zone_pkg::*; ();
    logic periodEnd;
    zone_t zone;
    logic active;
    algo_t algo;
    logic [4:0] downExtra;
    zone_t target;
    modport ctrl (output periodEnd, zone, active, algo, downExtra, input target);
    modport mapper (input periodEnd, zone, active, algo, downExtra, output target);
endinterface: mapper_if
`default_nettype wire

// [logic/zone_mapper.sv]
`timescale 1ns/10ps
`default_nettype none
module zone_mapper import light_zone_pkg::*; (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Zone sequence in, target out
    mapper_if.mapper m
);
    zone_t last_q;
    zone_t target_q;
    logic dirUp_q;
    logic qual_q;
    logic [5:0] count_q;

    wire logic up = m.zone > last_q;
    wire logic chg = m.zone != last_q;
    wire logic dirNext = chg ? up : dirUp_q;
    wire logic restart = chg && (count_q == 6'd0 || up != dirUp_q);
    wire logic [5:0] countNext = restart ? 6'd1 : ((count_q == 6'd0) ? 6'd0 : count_q + 6'd1);
    // Down-delay stretches only the downward qualification
    wire logic [5:0] needDown = (m.algo == ALGO_DOWN_DELAY) ?
        6'(QUAL_PERIODS + DOWN_EXTRA_BASE) + 6'(m.downExtra) : 6'(QUAL_PERIODS);
    wire logic [5:0] need = dirNext ? 6'(QUAL_PERIODS) : needDown;
    wire logic reached = countNext != 6'd0 && countNext >= need;
    wire logic allowed = !(m.algo == ALGO_UP_ONLY && !dirNext);
    wire logic sameAgain = qual_q && chg && up == dirUp_q;

    always_ff @(posedge clock) begin
        if (!rstn || !m.active) begin
            last_q <= 3'h0;
            target_q <= 3'h0;
            dirUp_q <= 1'b0;
            qual_q <= 1'b0;
            count_q <= 6'h00;
        end else if (m.periodEnd) begin
            last_q <= m.zone;
            if (qual_q) begin
                if (sameAgain && allowed) begin
                    target_q <= m.zone;
                end else begin
                    qual_q <= 1'b0;
                    count_q <= chg ? 6'd1 : 6'd0;
                    dirUp_q <= up;
                end
            end else begin
                dirUp_q <= dirNext;
                if (reached && allowed) begin
                    target_q <= m.zone;
                    qual_q <= 1'b1;
                    count_q <= 6'h00;
                end else begin
                    count_q <= countNext;
                end
            end
        end
    end

    assign m.target = target_q;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    chk_change_period_start: assert property ($changed(target_q) |-> $past(m.periodEnd) || !$past(m.active))
        else $error("target moved outside a period boundary");
    chk_target_held_zone: assert property (m.active && $past(m.active) && $changed(target_q) |-> target_q == $past(m.zone))
        else $error("target is not the held zone");
    chk_up_only_rise: assert property (m.active && $past(m.algo) == ALGO_UP_ONLY && $past(m.active) |-> target_q >= $past(target_q))
        else $error("up-only mapper moved down");
    chk_qual_drop: assert property (qual_q && m.periodEnd && !chg && m.active |=> !qual_q)
        else $error("qualification kept after quiet period");
    chk_counter_clear: assert property (!m.active |=> count_q == 6'd0 && !qual_q)
        else $error("counter not cleared when disabled");
    chk_three_up: assert property (m.active && m.periodEnd && !qual_q && count_q == 6'd2 && !restart && dirUp_q |=> target_q == $past(m.zone))
        else $error("third upward period did not move target");
    cover_down_delay_move: cover property (m.algo == ALGO_DOWN_DELAY && m.active ##1 target_q < $past(target_q));
endmodule: zone_mapper
`default_nettype wire

// [logic/ambient_light_zone_controller.sv]
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - three mappers; first fixed to bank one
// - each zone target is 8-bit code
// - per-zone PWM scaling enable
// - config bit 1 selects analog/PWM sensor
// - analog mode offers 128 resistor settings
// - 8-bit converter, 0xFF equals 2 V
// - PWM mode forces resistor high impedance
// - converter runs when enabled, 140 us refresh
// - average over bits 5:3 period, publish
// - held zone latched each period end
// - zone starts at zero on enable
// - three fast 1.1 ms periods at start
// - mapper picks direct, up-only, down-delay
// - upward move needs three qualifying periods
// - downward move needs three qualifying periods outside down-delay mode
// - same-direction change after qualifying moves immediately
// - quiet or reverse period drops qualification
// - target changes only at period start
// - new target follows held zone
// - direct moves both up and down
// - zones use four high/low hysteresis boundaries
module ambient_light_zone_controller import light_zone_pkg::*; #(
    parameter int SAMPLE_CYCLES_P = SAMPLE_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic regWrEn,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData_q,
    // Converter and sensor front end
    input wire logic [7:0] adcCode,
    output logic adcRun_q,
    output logic sensorPwmMode_q,
    output logic [6:0] inputResistor_q,
    // Zone and bank results
    output zone_t ambientZone_q,
    output logic [NUM_BANKS-1:0][7:0] bankCode_q,
    output logic [NUM_BANKS-1:0] bankPwmScale_q
);
    // Software registers
    logic [7:0] cfg_q;
    logic [6:0] resSel_q;
    logic [5:0] algo_q;
    logic [5:0] bankAsg_q;
    logic [4:0] pwmZone_q;
    logic [4:0] downDelay_q;
    logic [NUM_BOUNDS-1:0][7:0] boundHi_q;
    logic [NUM_BOUNDS-1:0][7:0] boundLo_q;
    logic [NUM_MAPPERS*NUM_ZONES-1:0][7:0] target_q;

    // Sensing path
    logic [7:0] adcMeta_q;
    logic [7:0] adcSync_q;
    logic [7:0] adcLast_q;
    logic [7:0] adcStable_q;
    sense_t state_q;
    logic [1:0] fastLeft_q;
    logic [15:0] tick_q;
    logic [11:0] sampIdx_q;
    logic [18:0] sum_q;
    logic [7:0] sample_q;
    logic [7:0] avg_q;
    logic periodEnd_q;
    logic [7:0] rdMux;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] base, input int idx);
        return a == base + 8'(idx);
    endfunction: hit

    // hysteresis: climb past highs, else fall below lows
    function automatic zone_t classify(input logic [7:0] v, input zone_t z,
                                       input logic [NUM_BOUNDS-1:0][7:0] hi,
                                       input logic [NUM_BOUNDS-1:0][7:0] lo);
        zone_t r;
        r = z;
        for (int i = 0; i < NUM_BOUNDS; i++) begin
            if (r == zone_t'(i) && v > hi[i]) begin
                r = zone_t'(i + 1);
            end
        end
        if (r == z) begin
            for (int i = NUM_BOUNDS - 1; i >= 0; i--) begin
                if (r == zone_t'(i + 1) && v < lo[i]) begin
                    r = zone_t'(i);
                end
            end
        end
        return r;
    endfunction: classify

    // code lookup per mapper and zone
    function automatic logic [7:0] zoneTarget(input logic [NUM_MAPPERS*NUM_ZONES-1:0][7:0] t,
                                              input logic [1:0] mi, input zone_t z);
        return t[int'(mi) * NUM_ZONES + int'(z)];
    endfunction: zoneTarget

    wire logic enable = cfg_q[CFG_EN_BIT];
    wire logic pwmMode = cfg_q[CFG_PWM_BIT];
    wire logic [2:0] avgSel = cfg_q[CFG_AVG_LSB +: 3];
    wire logic fast = state_q == SENSE_FAST;
    wire logic running = state_q != SENSE_IDLE;
    wire logic sampleTick = running && tick_q == 16'(SAMPLE_CYCLES_P - 1);
    // period length is a power of two samples
    wire logic [3:0] avgShift = fast ? 4'(FAST_SHIFT) : 4'(NORMAL_SHIFT_BASE) + {1'b0, avgSel};
    wire logic [11:0] periodLen = 12'd1 << avgShift;
    wire logic lastSample = sampleTick && sampIdx_q >= periodLen - 12'd1;
    wire logic [18:0] sumNext = sum_q + 19'(adcStable_q);
    wire logic [7:0] avgNext = 8'(sumNext >> avgShift);
    wire zone_t zoneNext = classify(avgNext, ambientZone_q, boundHi_q, boundLo_q);

    // Register writes
    always_ff @(posedge clock) begin
        if (!rstn) begin
            cfg_q <= CFG_RST;
            resSel_q <= RES_SEL_RST;
            algo_q <= ALGO_RST;
            bankAsg_q <= BANK_ASG_RST;
            pwmZone_q <= PWM_ZONE_RST;
            downDelay_q <= DOWN_DELAY_RST;
            boundHi_q <= {NUM_BOUNDS{BOUND_RST}};
            boundLo_q <= {NUM_BOUNDS{BOUND_RST}};
            target_q <= {(NUM_MAPPERS*NUM_ZONES){TARGET_RST}};
        end else if (regWrEn) begin
            if (hit(regAddr, OFF_CFG, 0)) begin
                cfg_q <= regWrData;
            end
            if (hit(regAddr, OFF_RES_SEL, 0)) begin
                resSel_q <= regWrData[6:0];
            end
            if (hit(regAddr, OFF_ALGO, 0)) begin
                algo_q <= regWrData[5:0];
            end
            if (hit(regAddr, OFF_BANK_ASG, 0)) begin
                bankAsg_q <= regWrData[5:0];
            end
            if (hit(regAddr, OFF_PWM_ZONE, 0)) begin
                pwmZone_q <= regWrData[4:0];
            end
            if (hit(regAddr, OFF_DOWN_DELAY, 0)) begin
                downDelay_q <= regWrData[4:0];
            end
            for (int i = 0; i < NUM_BOUNDS; i++) begin
                if (hit(regAddr, OFF_BOUND_HI, i)) begin
                    boundHi_q[i] <= regWrData;
                end
                if (hit(regAddr, OFF_BOUND_LO, i)) begin
                    boundLo_q[i] <= regWrData;
                end
            end
            for (int i = 0; i < NUM_MAPPERS * NUM_ZONES; i++) begin
                if (hit(regAddr, OFF_TARGET, i)) begin
                    target_q[i] <= regWrData;
                end
            end
        end
    end

    // Read decode; unmapped addresses read zero
    always_comb begin
        rdMux = 8'h00;
        if (hit(regAddr, OFF_CFG, 0)) rdMux = cfg_q;
        if (hit(regAddr, OFF_RES_SEL, 0)) rdMux = {1'b0, resSel_q};
        if (hit(regAddr, OFF_ALGO, 0)) rdMux = {2'b00, algo_q};
        if (hit(regAddr, OFF_BANK_ASG, 0)) rdMux = {2'b00, bankAsg_q};
        if (hit(regAddr, OFF_PWM_ZONE, 0)) rdMux = {3'b000, pwmZone_q};
        if (hit(regAddr, OFF_DOWN_DELAY, 0)) rdMux = {3'b000, downDelay_q};
        if (hit(regAddr, OFF_SAMPLE, 0)) rdMux = sample_q;
        if (hit(regAddr, OFF_AVERAGE, 0)) rdMux = avg_q;
        if (hit(regAddr, OFF_ZONE, 0)) rdMux = {5'b00000, ambientZone_q};
        for (int i = 0; i < NUM_BOUNDS; i++) begin
            if (hit(regAddr, OFF_BOUND_HI, i)) rdMux = boundHi_q[i];
            if (hit(regAddr, OFF_BOUND_LO, i)) rdMux = boundLo_q[i];
        end
        for (int i = 0; i < NUM_MAPPERS * NUM_ZONES; i++) begin
            if (hit(regAddr, OFF_TARGET, i)) rdMux = target_q[i];
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            regRdData_q <= 8'h00;
        end else begin
            regRdData_q <= rdMux;
        end
    end

    // Async converter word: 2-flop capture, then kept only when two syncs agree, so no torn word gets in
    always_ff @(posedge clock) begin
        if (!rstn) begin
            adcMeta_q <= 8'h00;
            adcSync_q <= 8'h00;
            adcLast_q <= 8'h00;
            adcStable_q <= 8'h00;
        end else begin
            adcMeta_q <= adcCode;
            adcSync_q <= adcMeta_q;
            adcLast_q <= adcSync_q;
            adcStable_q <= (adcSync_q == adcLast_q) ? adcSync_q : adcStable_q;
        end
    end

    // Front-end steering outputs
    always_ff @(posedge clock) begin
        if (!rstn) begin
            adcRun_q <= 1'b0;
            sensorPwmMode_q <= 1'b0;
            inputResistor_q <= RES_HIGHZ;
        end else begin
            adcRun_q <= enable;
            sensorPwmMode_q <= pwmMode;
            inputResistor_q <= pwmMode ? RES_HIGHZ : resSel_q;
        end
    end

    // Sampling, averaging and zone latch
    always_ff @(posedge clock) begin
        if (!rstn) begin
            state_q <= SENSE_IDLE;
            fastLeft_q <= 2'd0;
            tick_q <= 16'h0000;
            sampIdx_q <= 12'h000;
            sum_q <= 19'h00000;
            sample_q <= 8'h00;
            avg_q <= 8'h00;
            ambientZone_q <= 3'h0;
            periodEnd_q <= 1'b0;
        end else if (!enable) begin
            state_q <= SENSE_IDLE;
            periodEnd_q <= 1'b0;
        end else begin
            periodEnd_q <= 1'b0;
            case (state_q)
                SENSE_IDLE: begin
                    // predictable zone 0, then fast periods
                    state_q <= SENSE_FAST;
                    fastLeft_q <= 2'(FAST_PERIOD_COUNT);
                    ambientZone_q <= 3'h0;
                    tick_q <= 16'h0000;
                    sampIdx_q <= 12'h000;
                    sum_q <= 19'h00000;
                end
                SENSE_FAST, SENSE_NORMAL: begin
                    tick_q <= sampleTick ? 16'h0000 : tick_q + 16'd1;
                    if (sampleTick) begin
                        sample_q <= adcStable_q;
                        if (lastSample) begin
                            avg_q <= avgNext;
                            ambientZone_q <= zoneNext;
                            periodEnd_q <= 1'b1;
                            sum_q <= 19'h00000;
                            sampIdx_q <= 12'h000;
                            if (fast) begin
                                fastLeft_q <= fastLeft_q - 2'd1;
                                if (fastLeft_q == 2'd1) begin
                                    state_q <= SENSE_NORMAL;
                                end
                            end
                        end else begin
                            sum_q <= sumNext;
                            sampIdx_q <= sampIdx_q + 12'd1;
                        end
                    end
                end
                default: begin
                    state_q <= SENSE_IDLE;
                end
            endcase
        end
    end

    // Zone mappers
    mapper_if mIf [NUM_MAPPERS] ();
    zone_t mapZone [NUM_MAPPERS];

    for (genvar g = 0; g < NUM_MAPPERS; g++) begin : g_map
        assign mIf[g].periodEnd = periodEnd_q;
        assign mIf[g].zone = ambientZone_q;
        // mapper state clears with the enable
        assign mIf[g].active = enable && running;
        assign mIf[g].algo = algo_t'(algo_q[2*g +: 2]);
        assign mIf[g].downExtra = downDelay_q;
        assign mapZone[g] = mIf[g].target;
        zone_mapper uMapper (
            .clock(clock),
            .rstn(rstn),
            .m(mIf[g].mapper)
        );
    end

    // Bank routing; third mapper wins if both claim a bank
    logic [NUM_BANKS-1:0][7:0] bankCode_d;
    logic [NUM_BANKS-1:0] bankPwm_d;

    for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
        // bank one fixed, others by assignment
        wire logic pick3 = (b != 0) && bankAsg_q[5:3] == 3'(b - 1);
        wire logic pick2 = (b != 0) && bankAsg_q[2:0] == 3'(b - 1);
        wire logic used = (b == 0) || pick3 || pick2;
        wire logic [1:0] src = (b == 0) ? 2'd0 : (pick3 ? 2'd2 : 2'd1);
        wire zone_t srcZone = mapZone[src];
        assign bankCode_d[b] = used ? zoneTarget(target_q, src, srcZone) : 8'h00;
        assign bankPwm_d[b] = used && pwmZone_q[srcZone];
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            bankCode_q <= {NUM_BANKS{8'h00}};
            bankPwmScale_q <= {NUM_BANKS{1'b0}};
        end else begin
            bankCode_q <= bankCode_d;
            bankPwmScale_q <= bankPwm_d;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    chk_pwm_highz: assert property (cfg_q[CFG_PWM_BIT] |=> inputResistor_q == RES_HIGHZ)
        else $error("PWM mode resistor not high impedance");
    chk_analog_res: assert property (!cfg_q[CFG_PWM_BIT] |=> inputResistor_q == $past(resSel_q))
        else $error("analog resistor select not applied");
    chk_sample_refresh: assert property ($changed(sample_q) |-> $past(sampleTick))
        else $error("sample readback changed off tick");
    chk_idle_converter: assert property (!enable ##1 !enable |-> !adcRun_q && !sampleTick)
        else $error("converter active while disabled");
    chk_avg_publish: assert property (lastSample && enable |=> avg_q == $past(avgNext) && periodEnd_q)
        else $error("average not published at period end");
    chk_zone_latch: assert property ($changed(ambientZone_q) |-> $past(lastSample) || $past(state_q) == SENSE_IDLE)
        else $error("held zone moved mid period");
    chk_zone_start: assert property (state_q == SENSE_IDLE && enable |=> ambientZone_q == 3'h0)
        else $error("zone not zero at start");
    chk_fast_start: assert property (state_q == SENSE_IDLE && enable |=> fast && fastLeft_q == 2'(FAST_PERIOD_COUNT))
        else $error("fast start not entered");
    chk_fast_len: assert property (fast |-> periodLen == 12'(FAST_SAMPLES))
        else $error("fast period length wrong");
    chk_zone_range: assert property (ambientZone_q <= zone_t'(NUM_ZONES - 1))
        else $error("zone index out of range");
    chk_bank1_route: assert property (##1 bankCode_q[0] == zoneTarget($past(target_q), 2'd0, $past(mapZone[0])))
        else $error("bank one not served by first mapper");

    cover_fast_done: cover property (fast ##1 state_q == SENSE_NORMAL);
    cover_zone_up: cover property (periodEnd_q && ambientZone_q > $past(ambientZone_q));
    cover_bank_move: cover property (enable ##1 $changed(bankCode_q[0]));
    cover_pwm_mode: cover property (sensorPwmMode_q && periodEnd_q);
endmodule: ambient_light_zone_controller
`default_nettype wire

// [verif/sensor_model.sv]
`timescale 1ns/10ps
`default_nettype none
module sensor_model (
    // Clock and light level
    input wire logic clock,
    input wire logic [11:0] inputMv,
    // Converter result
    output logic [7:0] adcCode
);
    always_ff @(posedge clock) begin
        adcCode <= (inputMv >= 12'd2000) ? 8'hff : 8'((32'(inputMv) * 255) / 2000);
    end
endmodule: sensor_model
`default_nettype wire

// [verif/tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tb import light_zone_pkg::*;;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic regWrEn = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWrData = 8'h00;
    logic [11:0] inputMv = 12'h000;
    logic [7:0] regRdData_q, adcCode;
    logic adcRun_q, sensorPwmMode_q;
    logic [6:0] inputResistor_q;
    zone_t ambientZone_q;
    logic [NUM_BANKS-1:0][7:0] bankCode_q;
    logic [NUM_BANKS-1:0] bankPwmScale_q;
    logic [7:0] tgt [3][5];
    logic [7:0] hiB [4] = '{8'h40, 8'h80, 8'hc0, 8'hf0};
    int mvMid [5] = '{60, 700, 1200, 1700, 1950};
    int err_count = 0;
    int num_checks = 0;
    int cycles = 0;
    int seed = 32'h9d37;

    always #10 clock = ~clock;

    // Short sample tick keeps periods at 32 to 128 cycles
    ambient_light_zone_controller #(.SAMPLE_CYCLES_P(4)) dut (.clock(clock), .rstn(rstn), .regAddr(regAddr),
        .regWrEn(regWrEn), .regWrData(regWrData), .regRdData_q(regRdData_q), .adcCode(adcCode),
        .adcRun_q(adcRun_q), .sensorPwmMode_q(sensorPwmMode_q), .inputResistor_q(inputResistor_q),
        .ambientZone_q(ambientZone_q), .bankCode_q(bankCode_q), .bankPwmScale_q(bankPwmScale_q));
    sensor_model sensor (.clock(clock), .inputMv(inputMv), .adcCode(adcCode));

    function automatic logic [7:0] codeOf(input int mv);
        return (mv >= 2000) ? 8'hff : 8'(mv * 255 / 2000);
    endfunction: codeOf

    task automatic complete_run;
        $display("Checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask: complete_run

    always @(posedge clock) begin
        cycles++;
        if (cycles == 30000) begin
            err_count++;
            complete_run();
        end
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask: check

    task automatic waitc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask: waitc

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        #1 regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(posedge clock);
        #1 regWrEn = 1'b0;
    endtask: wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        #1 regAddr = a;
        @(posedge clock);
        #1 d = regRdData_q;
    endtask: rd

    // Seventeen normal periods: enough for any qualification to finish
    task automatic settle(input int z);
        logic [7:0] d;
        inputMv = 12'(mvMid[z]);
        waitc(1100);
        check("zone", 8'(ambientZone_q), 8'(z));
        rd(OFF_SAMPLE, d);
        check("sample", d, codeOf(mvMid[z]));
        rd(OFF_AVERAGE, d);
        check("average", d, codeOf(mvMid[z]));
        rd(OFF_ZONE, d);
        check("zoneReg", d, 8'(z));
    endtask: settle

    task automatic banks(input int z0, input int z1);
        check("bank1", bankCode_q[0], tgt[0][z0]);
        check("bankB", bankCode_q[1], tgt[1][z1]);
        check("bankC", bankCode_q[2], tgt[2][z1]);
        for (int b = 3; b < NUM_BANKS; b++) check("bankFree", bankCode_q[b], 8'h00);
    endtask: banks

    initial begin
        logic [7:0] d;
        int z;
        logic [4:0] pwmZ;
        inputMv = 12'(mvMid[2]);
        waitc(8);
        rstn = 1'b1;
        rd(OFF_BOUND_HI, d);
        check("boundRst", d, BOUND_RST);
        rd(OFF_BANK_ASG, d);
        check("asgRst", d, {2'b00, BANK_ASG_RST});
        rd(8'h7f, d);
        check("unmapped", d, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(8'(OFF_BOUND_HI + i), hiB[i]);
            wr(8'(OFF_BOUND_LO + i), hiB[i] - 8'h10);
        end
        for (int m = 0; m < 3; m++) for (int k = 0; k < 5; k++) begin
            tgt[m][k] = 8'($random(seed));
            wr(8'(OFF_TARGET + 5 * m + k), tgt[m][k]);
        end
        rd(OFF_TARGET + 8'h0e, d);
        check("targetRd", d, tgt[2][4]);
        wr(OFF_BANK_ASG, 8'h08);
        wr(OFF_RES_SEL, 8'h55);
        wr(OFF_CFG, 8'h03);
        waitc(2);
        check("resPwm", {1'b0, inputResistor_q}, 8'h00);
        check("pwmMode", {7'h00, sensorPwmMode_q}, 8'h01);
        check("run", {7'h00, adcRun_q}, 8'h01);
        check("zoneInit", 8'(ambientZone_q), 8'h00);
        wr(OFF_CFG, 8'h01);
        waitc(2);
        check("resAnalog", {1'b0, inputResistor_q}, 8'h55);
        check("anaMode", {7'h00, sensorPwmMode_q}, 8'h00);
        waitc(115);
        check("fastZone", 8'(ambientZone_q), 8'h02);
        banks(2, 2);
        wr(OFF_ALGO, 8'h01);
        settle(0);
        banks(2, 0);
        // Down-delay mappers now need eight periods downward
        wr(OFF_DOWN_DELAY, 8'h02);
        for (int n = 0; n < 10; n++) begin
            z = ($random(seed) & 32'h7fffffff) % 5;
            pwmZ = 5'($random(seed));
            wr(OFF_ALGO, {2'b00, n[0], 1'b0, n[1], 1'b0, 2'b00});
            wr(OFF_PWM_ZONE, {3'b000, pwmZ});
            settle(z);
            banks(z, z);
            check("pwmScale", {7'h00, bankPwmScale_q[0]}, {7'h00, pwmZ[z]});
            check("pwmScaleB", {7'h00, bankPwmScale_q[1]}, {7'h00, pwmZ[z]});
        end
        // Longer averaging period of 32 samples
        wr(OFF_CFG, 8'h09);
        settle(4);
        banks(4, 4);
        wr(OFF_CFG, 8'h00);
        waitc(2);
        check("stop", {7'h00, adcRun_q}, 8'h00);
        banks(0, 0);
        // Restart from a nonzero held zone
        wr(OFF_CFG, 8'h01);
        waitc(2);
        check("zoneRestart", 8'(ambientZone_q), 8'h00);
        complete_run();
    end
endmodule: tb
`default_nettype wire
